// >>> rtl/ifd_pkg.sv
package ifd_pkg;
    // ---------------------------------------------------------------
    // register map (word-aligned byte addresses)
    // ---------------------------------------------------------------
    localparam logic [3:0] ADR_INSTR = 4'h0;
    localparam logic [3:0] ADR_CTRL = 4'h4;
    localparam logic [3:0] ADR_FIELDS = 4'h8;
    localparam logic [3:0] ADR_STATUS = 4'hC;
    // ---------------------------------------------------------------
    // instruction fields
    // ---------------------------------------------------------------
    localparam int IW = 16;
    localparam int FILE_LSB = 0;
    localparam int FILE_W = 8;
    localparam int PER_LSB = 8;
    localparam int PER_W = 5;
    localparam int DEST_BIT = 8;
    localparam int TBL_INC_BIT = 8;
    localparam int TBL_HI_BIT = 9;
    localparam int BITNUM_LSB = 8;
    localparam int BITNUM_W = 3;
    localparam int LIT8_W = 8;
    localparam int LIT11_W = 11;
    localparam int GLOBAL_IRQ_DISABLE_BIT = 4;
    localparam int Q_PHASES = 4;
    localparam logic [1:0] Q_LAST = 2'h3;
    localparam logic [7:0] STATUS_RST = 8'hC0;
    // ---------------------------------------------------------------
    // instruction classes and destinations
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {IFD_BYTE, IFD_BIT, IFD_LIT, IFD_CTRL} ifd_class_t;
    typedef enum logic [1:0] {IFD_TO_ACC, IFD_TO_FILE, IFD_TO_BOTH, IFD_TO_NONE} ifd_dest_t;
    typedef struct packed {
        ifd_class_t cls;
        ifd_dest_t dest;
        logic [7:0] file_addr;
        logic [4:0] per_addr;
        logic [2:0] bit_num;
        logic [10:0] literal;
        logic lit_wide;
        logic tbl_op;
        logic tbl_inc;
        logic tbl_hi;
        logic two_cycle;
        logic cond_two;
        logic changes_pc;
        logic reserved;
        logic [5:0] op_index;
    } ifd_dec_t;
endpackage

// >>> rtl/ifd_field_reg.sv
`timescale 1ns/1ps
`default_nettype none
module ifd_field_reg #(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= RST;
        end else if (we_i) begin
            q_o <= d_i;
        end
    end
endmodule // ifd_field_reg
`default_nettype wire

// >>> rtl/ifd_decoder.sv
// Overview of operation
// - each instruction is one 16-bit word
// - decode 58 instructions in three groups
// - d=0 to accumulator, d=1 to file
// - file address field is eight bits
// - peripheral address field is five bits
// - i=1 increments table pointer after execution
// - t selects latch low or high byte
// - s=0 file and accumulator, s=1 file
// - bit field selects bit within register
// - literal is eight or eleven bits
// - taken skips, branches, table ops take two cycles
// - instruction cycle is four clock periods
// - global irq disable at status bit four
// - 16-bit table pointer and split latch
// - four phases: decode, read, execute, write
// - taken skip turns fetched word into no-op
`timescale 1ns/1ps
`default_nettype none
module ifd_decoder (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic [15:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic cond_true_i,
    output ifd_pkg::ifd_dec_t dec_o,
    output logic [1:0] q_phase_o,
    output logic cycle_start_o,
    output logic force_nop_o,
    output logic [15:0] table_pointer_o,
    output logic [15:0] table_latch_o,
    output logic global_irq_disable_o
);
    import ifd_pkg::*;

    // ---------------------------------------------------------------
    // phase counter
    // ---------------------------------------------------------------
    logic [1:0] q_cnt;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_cnt <= '0;
        end else begin
            q_cnt <= q_cnt + 2'h1;
        end
    end
    wire logic q_end = (q_cnt == Q_LAST);

    // ---------------------------------------------------------------
    // combinational decode
    // ---------------------------------------------------------------
    logic [15:0] iw;
    ifd_dec_t next_dec;
    always_comb begin
        next_dec = '0;
        next_dec.cls = IFD_BYTE;
        next_dec.dest = IFD_TO_NONE;
        next_dec.file_addr = iw[FILE_LSB +: FILE_W];
        next_dec.per_addr = iw[PER_LSB +: PER_W];
        next_dec.bit_num = iw[BITNUM_LSB +: BITNUM_W];
        next_dec.literal = {3'h0, iw[7:0]};
        next_dec.tbl_inc = iw[TBL_INC_BIT];
        next_dec.tbl_hi = iw[TBL_HI_BIT];
        next_dec.op_index = 6'h00;
        // whole-word decode into the instruction set
        casez (iw)
            16'b0000_0000_0000_0000: next_dec.op_index = 6'h00; // no-op
            16'b0000_0001_????_????: begin next_dec.dest = IFD_TO_FILE; next_dec.op_index = 6'h01; end
            16'b0000_001?_????_????, 16'b0000_01??_????_????, 16'b0000_1???_????_????,
            16'b0001_00??_????_????, 16'b0001_010?_????_????, 16'b0001_10??_????_????,
            16'b0001_110?_????_????, 16'b0010_00??_????_????: begin
                next_dec.dest = iw[DEST_BIT] ? IFD_TO_FILE : IFD_TO_ACC;
                next_dec.op_index = {1'b0, iw[13:9]};
            end
            16'b0001_011?_????_????, 16'b0001_111?_????_????, 16'b0010_01??_????_????: begin
                next_dec.dest = iw[DEST_BIT] ? IFD_TO_FILE : IFD_TO_ACC;
                next_dec.cond_two = 1'b1;
                next_dec.op_index = {1'b0, iw[13:9]};
            end
            16'b0010_1???_????_????: begin
                next_dec.dest = iw[DEST_BIT] ? IFD_TO_FILE : IFD_TO_BOTH;
                next_dec.op_index = {1'b0, iw[13:9]};
            end
            16'b0011_00??_????_????: begin
                next_dec.cond_two = (iw[9:8] != 2'h3);
                next_dec.reserved = (iw[9:8] == 2'h3);
                next_dec.op_index = 6'h20;
            end
            16'b0011_0100_????_????: next_dec.op_index = 6'h21;
            16'b01??_????_????_????: begin
                next_dec.dest = IFD_TO_FILE;
                next_dec.op_index = iw[13] ? 6'h23 : 6'h22;
            end
            16'b10??_????_????_????: begin
                next_dec.cls = IFD_BIT;
                next_dec.bit_num = iw[10:8];
                next_dec.cond_two = iw[13] ^ iw[12] ? 1'b0 : 1'b1;
                next_dec.tbl_op = (iw[13:11] == 3'h5) || (iw[13:12] == 2'h2 && iw[11]);
                next_dec.two_cycle = next_dec.tbl_op;
                if (next_dec.tbl_op) begin
                    next_dec.cls = IFD_BYTE;
                    next_dec.cond_two = 1'b0;
                end
                next_dec.op_index = {3'h3, iw[13:11]};
            end
            16'b110?_????_????_????, 16'b111?_????_????_????: begin
                next_dec.cls = IFD_CTRL;
                next_dec.literal = iw[10:0];
                next_dec.lit_wide = 1'b1;
                next_dec.changes_pc = 1'b1;
                next_dec.two_cycle = 1'b1;
                next_dec.op_index = iw[13] ? 6'h2D : 6'h2C;
            end
            16'b1011_????_????_????: begin
                next_dec.cls = IFD_LIT;
                next_dec.op_index = {2'h3, iw[11:8]};
            end
            default: next_dec.reserved = 1'b1; // undefined, run as no-op
        endcase
        if (next_dec.reserved) begin
            next_dec.dest = IFD_TO_NONE;
        end
    end

    // ---------------------------------------------------------------
    // fetch, flush and cycle sequencing
    // ---------------------------------------------------------------
    ifd_dec_t dec;
    logic flush;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            iw <= '0;
            dec <= '0;
            flush <= 1'b0;
        end else if (q_end) begin
            iw <= instr_valid_i ? instr_i : 16'h0000;
            dec <= next_dec;
            // stale prefetch never executes after a branch or taken skip
            flush <= (dec.two_cycle || (dec.cond_two && cond_true_i)) && !flush;
        end
    end

    // ---------------------------------------------------------------
    // table pointer, latch and cpu status
    // ---------------------------------------------------------------
    logic [15:0] tptr;
    logic [15:0] tlat;
    logic [7:0] cpu_status_reg;
    // only the low nibble decodes; anything above it is unmapped and must not alias
    wire logic adr_hit = (wb_adr_i[31:4] == 28'h0000000);
    wire logic bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && adr_hit;
    wire logic ctl_wr = bus_wr && (wb_adr_i[3:0] == ADR_CTRL);
    wire logic tbl_done = q_end && dec.tbl_op && !flush;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tptr <= '0;
        end else if (ctl_wr && wb_sel_i[1:0] == 2'h3) begin
            tptr <= wb_dat_i[15:0];
        end else if (tbl_done && dec.tbl_inc) begin
            tptr <= tptr + 16'h0001;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tlat <= '0;
        end else if (ctl_wr && wb_sel_i[3]) begin
            tlat[15:8] <= wb_dat_i[31:24];
        end else if (ctl_wr && wb_sel_i[2]) begin
            tlat[7:0] <= wb_dat_i[23:16];
        end else if (tbl_done) begin
            if (dec.tbl_hi) begin
                tlat[15:8] <= dec.file_addr;
            end else begin
                tlat[7:0] <= dec.file_addr;
            end
        end
    end
    ifd_field_reg #(.W(8), .RST(STATUS_RST)) u_status (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(bus_wr && wb_adr_i[3:0] == ADR_STATUS && wb_sel_i[0]),
        .d_i(wb_dat_i[7:0]),
        .q_o(cpu_status_reg)
    );

    // ---------------------------------------------------------------
    // wishbone slave, one wait-free ack
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && !adr_hit) begin
            wb_dat_o <= '0;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            case (wb_adr_i[3:0])
                ADR_INSTR: wb_dat_o <= {16'h0000, iw};
                ADR_CTRL: wb_dat_o <= {tlat, tptr};
                ADR_FIELDS: wb_dat_o <= {dec.op_index, 5'h00, dec.reserved, flush, dec.literal, dec.file_addr};
                ADR_STATUS: wb_dat_o <= {22'h0, q_cnt, cpu_status_reg};
                default: wb_dat_o <= '0;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign dec_o = dec;
    assign q_phase_o = q_cnt;
    assign cycle_start_o = (q_cnt == 2'h0);
    assign force_nop_o = flush || dec.reserved;
    assign table_pointer_o = tptr;
    assign table_latch_o = tlat;
    assign global_irq_disable_o = cpu_status_reg[GLOBAL_IRQ_DISABLE_BIT];
endmodule // ifd_decoder
`default_nettype wire

// >>> sim/ifd_decoder_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ifd_decoder_monitor
    import ifd_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [15:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic cond_true_i,
    input wire ifd_dec_t dec_o,
    input wire logic [1:0] q_phase_o,
    input wire logic cycle_start_o,
    input wire logic force_nop_o,
    input wire logic global_irq_disable_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_load;
        q_phase_o == Q_LAST && !force_nop_o;
    endsequence
    a_ack_follows: assert property (s_take |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_phase_wrap: assert property (q_phase_o == Q_LAST |=> q_phase_o == 2'h0) else $error("phase wrap");
    a_phase_step: assert property (q_phase_o != Q_LAST |=> q_phase_o == $past(q_phase_o) + 2'h1)
        else $error("phase step");
    a_start_phase: assert property (cycle_start_o == (q_phase_o == 2'h0)) else $error("start flag");
    a_dec_hold: assert property (q_phase_o != Q_LAST |=> $stable(dec_o)) else $error("decode moved");
    // decode trails the fetch by one instruction cycle: the word was sampled one load earlier
    a_file_field: assert property (q_phase_o == Q_LAST |=>
        dec_o.file_addr == ($past(instr_valid_i, 5) ? $past(instr_i[7:0], 5) : 8'h00)) else $error("file field");
    a_skip_flush: assert property (s_load ##0 dec_o.cond_two && cond_true_i |=> force_nop_o)
        else $error("skip not flushed");
    a_tbl_flush: assert property (s_load ##0 dec_o.two_cycle |=> force_nop_o) else $error("no flush");
    a_irq_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 32'h0000_000C |->
        wb_dat_o[GLOBAL_IRQ_DISABLE_BIT] == global_irq_disable_o) else $error("irq bit");
endmodule // ifd_decoder_monitor
bind ifd_decoder ifd_decoder_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .instr_i(instr_i), .instr_valid_i(instr_valid_i), .cond_true_i(cond_true_i),
    .dec_o(dec_o), .q_phase_o(q_phase_o), .cycle_start_o(cycle_start_o), .force_nop_o(force_nop_o),
    .global_irq_disable_o(global_irq_disable_o));
`default_nettype wire

// >>> sim/ifd_prog_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ifd_prog_mem (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [1:0] q_phase_i,
    input wire logic [15:0] word_i,
    input wire logic cond_i,
    output logic [15:0] instr_o,
    output logic valid_o,
    output logic cond_o
);
    // word shown in the sampling phase and again in phase 1; an inverted pattern otherwise catches mistimed loads
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            instr_o <= 16'h0000;
            valid_o <= 1'b0;
            cond_o <= 1'b0;
        end else if (q_phase_i == 2'h2) begin
            instr_o <= word_i;
            valid_o <= 1'b1;
            cond_o <= cond_i;
        end else begin
            instr_o <= ~instr_o;
            valid_o <= ~valid_o;
            cond_o <= ~cond_o;
        end
    end
endmodule // ifd_prog_mem
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import ifd_pkg::*;
    logic clk = 1'b0, rst = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0, cond = 1'b0;
    logic [31:0] adr = '0, wdat = '0, rd, dat, seed = 32'h0000_0032;
    logic [3:0] sel = 4'h0;
    logic [15:0] word = 16'h0000, instr, ptr_o, lat_o, ptr_m = 16'h0000, lat_m = 16'h0000, pend = 16'h0000;
    logic [15:0] fetched = 16'h0000;
    logic [7:0] hi[14] = '{8'h0E, 8'h0F, 8'h28, 8'h29, 8'h5F, 8'hAB, 8'h00, 8'hA8, 8'h00, 8'h31, 8'h00,
        8'h31, 8'h00, 8'h00};
    logic [1:0] q;
    logic valid, cond_q, ack, start, fnop, irq, pfl = 1'b0;
    ifd_dec_t dec;
    int fails = 0, n_tests = 0;
    always #5 clk = ~clk;
    ifd_decoder dut (.clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_we_i(we),
        .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .instr_i(instr), .instr_valid_i(valid),
        .cond_true_i(cond_q), .dec_o(dec), .q_phase_o(q), .cycle_start_o(start), .force_nop_o(fnop),
        .table_pointer_o(ptr_o), .table_latch_o(lat_o), .global_irq_disable_o(irq));
    ifd_prog_mem mem (.clk_i(clk), .rst_i(rst), .q_phase_i(q), .word_i(word), .cond_i(cond), .instr_o(instr),
        .valid_o(valid), .cond_o(cond_q));
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: value %h, model %h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: flag %b, model %b", $time, got, exp);
        end
    endtask
    task finish_test;
        if (fails == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    function logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        int t;
        @(posedge clk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (ack !== 1'b1 && t < 50);
        if (t >= 50) fails++;
        rd = dat;
        {cyc, stb} <= 2'b00;
    endtask
    // pend is the word whose decode sits on dec now; c is its test outcome
    task automatic step(input logic [15:0] w, input logic c);
        logic nf;
        do @(negedge clk); while (q !== 2'h1);
        cmp_flag(fnop, pfl);
        cmp(ptr_o, ptr_m);
        cmp(lat_o, lat_m);
        nf = !pfl && (pend[15:10] == 6'h2A || (pend[15:8] == 8'h31 && c));
        if (!pfl) begin
            cmp(dec.file_addr, pend[7:0]);
            if (pend[15:9] == 7'h07) cmp(dec.dest, pend[8] ? IFD_TO_FILE : IFD_TO_ACC);
            if (pend[15:9] == 7'h14) cmp(dec.dest, pend[8] ? IFD_TO_FILE : IFD_TO_BOTH);
            if (pend[15:13] == 3'h2) cmp(dec.per_addr, pend[12:8]);
            if (pend[15:8] == 8'h31) cmp_flag(dec.cond_two, 1'b1);
            if (pend[15:10] == 6'h2A) begin
                cmp({dec.tbl_op, dec.tbl_hi, dec.tbl_inc, dec.two_cycle}, {1'b1, pend[9:8], 1'b1});
                ptr_m = ptr_m + 16'(pend[8]);
                if (pend[9]) lat_m[15:8] = pend[7:0];
                else lat_m[7:0] = pend[7:0];
            end
        end
        @(posedge clk);
        word <= w;
        cond <= c;
        // decode shows a word one instruction cycle after it is fetched
        pend = fetched;
        fetched = w;
        pfl = nf;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, 32'h0000_000C, 32'h0, 4'hF);
        cmp(rd[7:0], STATUS_RST);
        cmp_flag(irq, 1'b0);
        wb(1'b1, 32'h0000_000C, 32'h0000_0010, 4'hF);
        wb(1'b1, 32'h0000_0004, 32'h0000_FFFF, 4'h3);
        ptr_m = 16'hFFFF;
        cmp_flag(irq, 1'b1);
        wb(1'b0, 32'h0000_0004, 32'h0, 4'hF);
        cmp(rd, {lat_m, ptr_m});
        wb(1'b0, 32'h0000_0010, 32'h0, 4'hF);
        cmp(rd, 32'h0);
        repeat (3) begin
            for (int i = 0; i < 14; i++) step((hi[i] == 8'h00) ? 16'h0000 : {hi[i], rnd()}, i == 11);
        end
        finish_test;
    end
    initial begin
        #100000;
        fails++;
        finish_test;
    end
endmodule // testbench
`default_nettype wire
